/* File: src/wbl_pkg.sv */
/*
  Package of the work bit logic unit: register map, field layout, reset
  values, combining operations and the struct type that carries the status signals.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package wbl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and time base
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned TICK_SEC     = 1;
  localparam int unsigned SEC_CYCLES   = TICK_SEC * CLK_HZ;
  localparam logic [5:0]  SEC_PER_MIN  = 6'h3C;
  localparam logic [13:0] DELAY_MAX    = 14'h270F;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SEL    = 8'h20;
  localparam logic [7:0] OFS_MODE   = 8'h40;
  localparam logic [7:0] OFS_DLY    = 8'h60;

  // Writable bits and reset values
  localparam logic [31:0] SEL_MASK   = 32'h3F3F_3F3F;
  localparam logic [31:0] MODE_MASK  = 32'h0000_00FF;
  localparam logic [31:0] DLY_MASK   = 32'h3FFF_3FFF;
  localparam logic [31:0] SEL_RST    = 32'h0000_0000;
  localparam logic [31:0] MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] DLY_RST    = 32'h0000_0000;
  localparam logic        UNIT_RST   = 1'b0;

  // Field positions
  localparam int unsigned CTRL_UNIT_BIT = 0;
  localparam int unsigned MODE_OINV_BIT = 3;
  localparam int unsigned MODE_IINV_LSB = 4;
  localparam int unsigned DLY_OFF_LSB   = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Combining operations
  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_AB_CD   = 3'h1,
    OP_AC_BD   = 3'h2,
    OP_ANY     = 3'h3,
    OP_ALL     = 3'h4
  } wbl_op_t;

  ////////////////////////////////////////////////////////////////////////
  // Status sources of the controller
  typedef struct packed {
    logic [3:0] event_in;
    logic [2:0] alarm;
    logic [1:0] count_alarm;
    logic       out1_on;
    logic       out1_linear;
    logic       out2_present;
    logic       out2_on;
    logic       out2_linear;
    logic       input_fault;
    logic       remote_setpoint_fault;
    logic       heater_burnout;
    logic       heater_short;
    logic       heater_overcurrent;
    logic [9:0] mode_flags;
    logic [1:0] time_signal;
    logic       program_end;
    logic       stage;
    logic [2:0] program_index;
    logic [4:0] segment_index;
  } wbl_status_t;

endpackage

/* File: src/wbl_unit.sv */
/*
  Work bit logic unit: eight programmable boolean work bits, each built
  from four selected status sources with polarity, combining operation,
  ON and OFF delay and output polarity, set up over AXI4-Lite.
  Assumes status inputs synchronous to CLK and a synchronous reset.
*/
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps

module wbl_unit #(
  parameter int unsigned SEC_CYCLES = wbl_pkg::SEC_CYCLES
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // Status sources
  input  wire wbl_pkg::wbl_status_t STATUS,
  // Work bits
  output logic [7:0]                WORK_BITS,
  // AXI4-Lite write
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY
);
  import wbl_pkg::*;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic              aw_full;
    logic              w_full;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              unit_min;
    logic [7:0][31:0]  sel;
    logic [7:0][31:0]  mode;
    logic [7:0][31:0]  dly;
    logic [31:0]       pre;
    logic [5:0]        mins;
    logic              tick;
    logic              first;
    logic [7:0]        held;
    logic [7:0]        wb;
    logic [7:0][13:0]  cnt;
  } wbl_state_t;

  wbl_state_t s_q;
  wbl_state_t s_d;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Source table and work bit evaluation
  logic [63:0] src;
  always_comb begin
    src        = 64'h0000_0000_0000_0000;
    src[0]     = 1'b0;
    src[1]     = 1'b1;
    src[2]     = s_q.first;
    src[6:3]   = STATUS.event_in;
    src[9:7]   = STATUS.alarm;
    src[10]    = |STATUS.count_alarm;
    src[11]    = STATUS.out1_on & ~STATUS.out1_linear;
    src[12]    = STATUS.out2_present & STATUS.out2_on
                 & ~STATUS.out2_linear;
    src[13]    = STATUS.input_fault;
    src[14]    = STATUS.remote_setpoint_fault;
    src[15]    = STATUS.heater_burnout;
    src[16]    = STATUS.heater_short;
    src[17]    = STATUS.heater_overcurrent;
    src[27:18] = STATUS.mode_flags;
    src[29:28] = STATUS.time_signal;
    src[30]    = STATUS.program_end;
    src[31]    = STATUS.stage;
    src[34:32] = STATUS.program_index;
    src[35]    = 1'b0;
    src[40:36] = STATUS.segment_index;
    src[48:41] = s_q.wb;
  end

  always_comb begin
    logic [3:0]  in;
    logic [13:0] lim;
    logic        raw;
    wbl_op_t     op;
    logic        none;
    in  = 4'h0;
    lim = 14'h0000;
    raw = 1'b0;
    op  = OP_NONE;
    none = 1'b0;
    s_d = s_q;

    // Time base: one-cycle tick per second or per minute
    s_d.tick = 1'b0;
    if (s_q.pre == 32'(SEC_CYCLES - 1)) begin
      s_d.pre = 32'h0000_0000;
      if (s_q.mins == SEC_PER_MIN - 6'h01) begin
        s_d.mins = 6'h00;
      end else begin
        s_d.mins = s_q.mins + 6'h01;
      end
      s_d.tick = s_q.unit_min ? (s_q.mins == SEC_PER_MIN - 6'h01) : 1'b1;
    end else begin
      s_d.pre = s_q.pre + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Work bits: select, invert, combine, delay
    s_d.first = 1'b0;

    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        in[k] = src[s_q.sel[i][8*k +: 6]]
                ^ s_q.mode[i][MODE_IINV_LSB + k];
      end
      op = wbl_op_t'(s_q.mode[i][2:0]);
      none = 1'b1;
      if (op inside {OP_AB_CD, OP_AC_BD, OP_ANY, OP_ALL}) begin
        none = 1'b0;
      end
      unique case (op)
        OP_AB_CD: raw = (in[0] & in[1]) | (in[2] & in[3]);
        OP_AC_BD: raw = (in[0] | in[2]) & (in[1] | in[3]);
        OP_ANY:   raw = |in;
        OP_ALL:   raw = &in;
        default:  raw = 1'b0;
      endcase
      lim = raw ? s_q.dly[i][13:0]
                : s_q.dly[i][DLY_OFF_LSB +: 14];
      if (raw == s_q.held[i]) begin
        s_d.cnt[i] = 14'h0000;
      end else if (lim == 14'h0000) begin
        s_d.held[i] = raw;
        s_d.cnt[i]  = 14'h0000;
      end else if (s_q.tick) begin
        if (s_q.cnt[i] + 14'h0001 >= lim) begin
          s_d.held[i] = raw;
          s_d.cnt[i]  = 14'h0000;
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + 14'h0001;
        end
      end
      if (none) begin
        s_d.held[i] = 1'b0;
        s_d.wb[i]   = 1'b0;
      end else begin
        s_d.wb[i] = s_d.held[i] ^ s_q.mode[i][MODE_OINV_BIT];
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    if (S_AXI_AWVALID && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.wdata  = S_AXI_WDATA;
      s_d.wstrb  = S_AXI_WSTRB;
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      if (s_q.awaddr[7:2] == OFS_CTRL[7:2]) begin
        if (s_q.wstrb[0]) begin
          s_d.unit_min = s_q.wdata[CTRL_UNIT_BIT];
        end
      end else if (s_q.awaddr[7:5] == OFS_SEL[7:5]) begin
        s_d.sel[s_q.awaddr[4:2]] = merge(s_q.sel[s_q.awaddr[4:2]],
                                         s_q.wdata, s_q.wstrb, SEL_MASK);
      end else if (s_q.awaddr[7:5] == OFS_MODE[7:5]) begin
        s_d.mode[s_q.awaddr[4:2]] = merge(s_q.mode[s_q.awaddr[4:2]],
                                          s_q.wdata, s_q.wstrb, MODE_MASK);
      end else if (s_q.awaddr[7:5] == OFS_DLY[7:5]) begin
        s_d.dly[s_q.awaddr[4:2]] = merge(s_q.dly[s_q.awaddr[4:2]],
                                         s_q.wdata, s_q.wstrb, DLY_MASK);
        for (int h = 0; h < 2; h++) begin
          if (s_d.dly[s_q.awaddr[4:2]][16*h +: 14] > DELAY_MAX) begin
            s_d.dly[s_q.awaddr[4:2]][16*h +: 14] = DELAY_MAX;
          end
        end
      end else if (s_q.awaddr[7:2] != OFS_STATUS[7:2]) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    s_d.awready = !s_d.aw_full;
    s_d.wready  = !s_d.w_full;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (S_AXI_ARADDR[7:2] == OFS_CTRL[7:2]) begin
        s_d.rdata[CTRL_UNIT_BIT] = s_q.unit_min;
      end else if (S_AXI_ARADDR[7:2] == OFS_STATUS[7:2]) begin
        s_d.rdata[7:0] = s_q.wb;
      end else if (S_AXI_ARADDR[7:5] == OFS_SEL[7:5]) begin
        s_d.rdata = s_q.sel[S_AXI_ARADDR[4:2]];
      end else if (S_AXI_ARADDR[7:5] == OFS_MODE[7:5]) begin
        s_d.rdata = s_q.mode[S_AXI_ARADDR[4:2]];
      end else if (S_AXI_ARADDR[7:5] == OFS_DLY[7:5]) begin
        s_d.rdata = s_q.dly[S_AXI_ARADDR[4:2]];
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q          <= '0;
      s_q.awready  <= 1'b1;
      s_q.wready   <= 1'b1;
      s_q.arready  <= 1'b1;
      s_q.unit_min <= UNIT_RST;
      s_q.sel      <= {8{SEL_RST}};
      s_q.mode     <= {8{MODE_RST}};
      s_q.dly      <= {8{DLY_RST}};
      s_q.first    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign WORK_BITS     = s_q.wb;
  assign S_AXI_AWREADY = s_q.awready;
  assign S_AXI_WREADY  = s_q.wready;
  assign S_AXI_BVALID  = s_q.bvalid;
  assign S_AXI_BRESP   = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arready;
  assign S_AXI_RVALID  = s_q.rvalid;
  assign S_AXI_RRESP   = s_q.rresp;
  assign S_AXI_RDATA   = s_q.rdata;

endmodule

/* File: verif/tb_wbl_unit.sv */
/*
  Testbench of the work bit logic unit: bus and status stimulus.
  Assumes wbl_pkg, wbl_unit and its bound checker.
*/
`timescale 1ns/10ps
module tb_wbl_unit;
  import wbl_pkg::*;
  logic        CLK = 0, RST = 1;
  wbl_status_t STATUS = '0;
  logic [7:0]  WORK_BITS, S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_BVALID;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  int          errors = 0, n_compared = 0, cycles = 0;
  always #2 CLK = ~CLK;
  wbl_unit #(.SEC_CYCLES(10)) dut_u (
    .CLK, .RST, .STATUS, .WORK_BITS, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 15000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    fork
      begin
        cyc(1);
        while (!S_AXI_AWREADY) cyc(1);
        S_AXI_AWVALID <= 1'b0;
      end
      begin
        cyc(1);
        while (!S_AXI_WREADY) cyc(1);
        S_AXI_WVALID <= 1'b0;
      end
    join
    while (!S_AXI_BVALID) cyc(1);
    S_AXI_BREADY <= 1'b1;
    cyc(1);
    S_AXI_BREADY <= 1'b0;
    cmp(S_AXI_BRESP, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    cyc(1);
    while (!S_AXI_ARREADY) cyc(1);
    S_AXI_ARVALID <= 1'b0;
    while (!S_AXI_RVALID) cyc(1);
    S_AXI_RREADY <= 1'b1;
    cyc(1);
    S_AXI_RREADY <= 1'b0;
    cmp(S_AXI_RDATA, e);
    cmp(S_AXI_RRESP, r);
  endtask
  task automatic rst();
    RST <= 1'b1;
    STATUS <= '0;
    cyc(2);
    RST <= 1'b0;
    cyc(1);
  endtask
  // Status word with only the source of one selector code raised
  function automatic wbl_status_t src(input int c);
    wbl_status_t s;
    s = '0;
    s.out2_present = 1'b1;
    case (c)
      3, 4, 5, 6: s.event_in[c-3] = 1'b1;
      7, 8, 9: s.alarm[c-7] = 1'b1;
      10: s.count_alarm = 2'h2;
      11: s.out1_on = 1'b1;
      12: s.out2_on = 1'b1;
      13: s.input_fault = 1'b1;
      14: s.remote_setpoint_fault = 1'b1;
      15: s.heater_burnout = 1'b1;
      16: s.heater_short = 1'b1;
      17: s.heater_overcurrent = 1'b1;
      18, 19, 20, 21, 22, 23, 24, 25, 26, 27: s.mode_flags[c-18] = 1'b1;
      28, 29: s.time_signal[c-28] = 1'b1;
      30: s.program_end = 1'b1;
      31: s.stage = 1'b1;
      32, 33, 34: s.program_index[c-32] = 1'b1;
      36, 37, 38, 39, 40: s.segment_index[c-36] = 1'b1;
      default: s.out2_present = 1'b1;
    endcase
    return s;
  endfunction
  function automatic logic opv(input int op, input logic [3:0] x);
    case (op)
      1: return (x[0] & x[1]) | (x[2] & x[3]);
      2: return (x[0] | x[2]) & (x[1] | x[3]);
      3: return |x;
      4: return &x;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk_src(input logic [31:0] c, input wbl_status_t s,
                         input logic e);
    STATUS <= s;
    wr(OFS_SEL, c, RESP_OKAY);
    cyc(3);
    cmp(WORK_BITS[0], e);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    cmp(WORK_BITS, 8'h00);
    rd(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(OFS_MODE + 8'h1C, 32'h0000_0000, RESP_OKAY);
    rd(OFS_DLY + 8'h1C, 32'h0000_0000, RESP_OKAY);
    rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0000_00FF, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    wr(OFS_DLY, 32'h3FFF_3FFF, RESP_OKAY);
    rd(OFS_DLY, 32'h270F_270F, RESP_OKAY);
    wr(OFS_DLY, 32'h0000_0000, RESP_OKAY);
    S_AXI_WSTRB <= 4'h3;
    wr(OFS_SEL + 8'h04, 32'h2A2A_2A2A, RESP_OKAY);
    S_AXI_WSTRB <= 4'hF;
    rd(OFS_SEL + 8'h04, 32'h0000_2A2A, RESP_OKAY);
  endtask
  task automatic t_codes();
    wbl_status_t s;
    logic e;
    wr(OFS_MODE, 32'h0000_0003, RESP_OKAY);
    for (int c = 0; c <= 40; c++) begin
      e = c == 1 || (c > 2 && c != 35);
      chk_src(c, src(c), e);
      chk_src(c, src(0), c == 1);
    end
    s = src(0);
    s.count_alarm = 2'h1;
    chk_src(10, s, 1'b1);
    s.out1_on = 1'b1;
    s.out1_linear = 1'b1;
    chk_src(11, s, 1'b0);
    s.out2_on = 1'b1;
    s.out2_present = 1'b0;
    chk_src(12, s, 1'b0);
    s.out2_present = 1'b1;
    s.out2_linear = 1'b1;
    chk_src(12, s, 1'b0);
  endtask
  task automatic t_ops();
    logic [3:0] iv;
    logic oi;
    logic e;
    for (int op = 0; op <= 7; op++) begin
      for (int p = 0; p < 16; p++) begin
        iv = 4'(op * 3);
        oi = p[0] ^ p[3];
        e = (op == 0 || op > 4) ? 1'b0 : opv(op, 4'(p) ^ iv) ^ oi;
        wr(OFS_SEL, {7'h0, p[3], 7'h0, p[2], 7'h0, p[1], 7'h0, p[0]},
           RESP_OKAY);
        wr(OFS_MODE, {24'h00_0000, iv, oi, 3'(op)}, RESP_OKAY);
        cyc(3);
        cmp(WORK_BITS[0], e);
      end
    end
  endtask
  task automatic t_feed();
    wr(OFS_SEL, 32'h0000_0003, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      if (k > 0)
        wr(OFS_SEL + 8'(4 * k), 32'(40 + k), RESP_OKAY);
      wr(OFS_MODE + 8'(4 * k), 32'h0000_0003, RESP_OKAY);
    end
    STATUS.event_in <= 4'h1;
    while (WORK_BITS[0] !== 1'b1) cyc(1);
    for (int k = 1; k < 8; k++) begin
      cmp(WORK_BITS[k], 1'b0);
      cyc(1);
      cmp(WORK_BITS[k], 1'b1);
    end
  endtask
  task automatic t_delay();
    wr(OFS_SEL, 32'h0000_0003, RESP_OKAY);
    wr(OFS_MODE, 32'h0000_0003, RESP_OKAY);
    wr(OFS_DLY, 32'h0002_0003, RESP_OKAY);
    STATUS.event_in <= 4'h1;
    cyc(15);
    STATUS.event_in <= 4'h0;
    cyc(3);
    STATUS.event_in <= 4'h1;
    cyc(15);
    cmp(WORK_BITS[0], 1'b0);
    cyc(20);
    cmp(WORK_BITS[0], 1'b1);
    STATUS.event_in <= 4'h0;
    cyc(5);
    cmp(WORK_BITS[0], 1'b1);
    cyc(20);
    cmp(WORK_BITS[0], 1'b0);
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    rd(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    STATUS.event_in <= 4'h1;
    cyc(1100);
    cmp(WORK_BITS[0], 1'b0);
    cyc(800);
    cmp(WORK_BITS[0], 1'b1);
  endtask
  initial begin
    cyc(12);
    RST <= 1'b0;
    cyc(1);
    t_regs();
    t_codes();
    rst();
    t_ops();
    rst();
    t_feed();
    rst();
    t_delay();
    print_verdict();
  end
endmodule

/* File: verif/wbl_unit_assertions.sv */
/*
  Checker of the work bit logic unit, bound to wbl_unit.
  Assumes it sees only the top ports; reset synchronous, active high.
*/
`timescale 1ns/10ps
module wbl_unit_assertions
  import wbl_pkg::*;
(
  // Clock, reset and work bits
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [7:0]  WORK_BITS,
  // Write channels
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  // Read channels
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_hs  = S_AXI_WVALID && S_AXI_WREADY;
  wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  chk_reset_clear:
    assert property ($past(RST) |-> WORK_BITS == 8'h00)
    else $error("work bits not clear after reset");
  chk_write_answer:
    assert property (aw_hs && w_hs |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  chk_aw_busy:
    assert property (aw_hs |=> !S_AXI_AWREADY)
    else $error("address ready while write pending");
  chk_bresp_hold:
    assert property (S_AXI_BVALID && !S_AXI_BREADY
      |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_read_answer:
    assert property (ar_hs |=> S_AXI_RVALID)
    else $error("read data missing");
  chk_ar_block:
    assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address ready while data pending");
  chk_rdata_hold:
    assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  chk_status_width:
    assert property (ar_hs && S_AXI_ARADDR == OFS_STATUS
      |=> S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("status word wider than eight bits");
  cover property (S_AXI_BVALID && S_AXI_BREADY);
  cover property (S_AXI_RVALID && S_AXI_RREADY);
  cover property (WORK_BITS == 8'hFF);
endmodule

bind wbl_unit wbl_unit_assertions chk_u (
  .CLK, .RST, .WORK_BITS, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RVALID, .S_AXI_RREADY);
